// ===== hdl/ddr3cd_defs.vh
// Constants shared by the DDR3 command bus decoder files
`ifndef DDR3CD_DEFS_VH
`define DDR3CD_DEFS_VH

// Layout of the synchronised sample vector, documented order, clock on top
`define DDR3CD_GRP_W      26
`define DDR3CD_BUS_CLK    25
`define DDR3CD_CKE_C_HI   24
`define DDR3CD_CKE_C_LO   23
`define DDR3CD_CKE_B_HI   22
`define DDR3CD_CKE_B_LO   21
`define DDR3CD_CKE_A_HI   20
`define DDR3CD_CKE_A_LO   19
`define DDR3CD_CS_C_HI    18
`define DDR3CD_CS_C_LO    17
`define DDR3CD_CS_B_HI    16
`define DDR3CD_CS_B_LO    15
`define DDR3CD_CS_A_HI    14
`define DDR3CD_CS_A_LO    11
`define DDR3CD_BA_HI      10
`define DDR3CD_BA_LO      8
`define DDR3CD_AHI_HI     7
`define DDR3CD_AHI_LO     5
`define DDR3CD_BC_N       4
`define DDR3CD_AP         3
`define DDR3CD_RAS_N      2
`define DDR3CD_CAS_N      1
`define DDR3CD_WE_N       0

// Command classification codes
`define DDR3CD_CMD_DESEL  4'h0
`define DDR3CD_CMD_MRS    4'h1
`define DDR3CD_CMD_REF    4'h2
`define DDR3CD_CMD_PRE    4'h3
`define DDR3CD_CMD_PREA   4'h4
`define DDR3CD_CMD_ACT    4'h5
`define DDR3CD_CMD_WR     4'h6
`define DDR3CD_CMD_WRA    4'h7
`define DDR3CD_CMD_RD     4'h8
`define DDR3CD_CMD_RDA    4'h9
`define DDR3CD_CMD_ZQCL   4'hA
`define DDR3CD_CMD_ZQCS   4'hB
`define DDR3CD_CMD_NOP    4'hC

// Slot codes
`define DDR3CD_SLOT_A     2'h0
`define DDR3CD_SLOT_B     2'h1
`define DDR3CD_SLOT_C     2'h2

// Burst length modes
`define DDR3CD_BL4        2'h0
`define DDR3CD_BL8        2'h1
`define DDR3CD_BL_OTF     2'h2

// Additive latency choices
`define DDR3CD_AL_ZERO    2'h0
`define DDR3CD_AL_CL_M1   2'h1
`define DDR3CD_AL_CL_M2   2'h2

// Latency limits in bus clock cycles
`define DDR3CD_CL_MIN     4'h5
`define DDR3CD_CL_MAX     4'hA
`define DDR3CD_CWL_MIN    4'h5
`define DDR3CD_CWL_MAX    4'h8

// Data schedule, bus clocks per burst (two beats per clock)
`define DDR3CD_SCHED_W    32
`define DDR3CD_BURST4_CLK 32'h0000_0003
`define DDR3CD_BURST8_CLK 32'h0000_000F

`endif

// ===== hdl/ddr3cd_sync.v
// Three stage pin synchroniser with second/third stage agreement filter
module ddr3cd_sync #(
    parameter W = 1
) (
    input  wire         mclk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;
    reg [W-1:0] st2;
    reg [W-1:0] st3;
    integer     i;

    // First stage feeds only the second; a bit moves once stages two and three agree
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            st2  <= {W{1'b0}};
            st3  <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            st2  <= meta;
            st3  <= st2;
            for (i = 0; i < W; i = i + 1) begin
                if (st2[i] == st3[i]) begin
                    q[i] <= st3[i];
                end
            end
        end
    end
endmodule // ddr3cd_sync

// ===== hdl/ddr3cd_rank_decode.v
// One-hot rank select decode qualified by the clock enables
module ddr3cd_rank_decode (
    input  wire [3:0] sel_n,
    input  wire [1:0] cke,
    output reg        hit,
    output reg  [1:0] rank
);
    // Exactly one select low; odd ranks need the upper enable, even the lower
    always @* begin
        hit  = 1'b0;
        rank = 2'h0;
        case (sel_n)
            4'hE: begin
                hit  = cke[0];
                rank = 2'h0;
            end
            4'hD: begin
                hit  = cke[1];
                rank = 2'h1;
            end
            4'hB: begin
                hit  = cke[0];
                rank = 2'h2;
            end
            4'h7: begin
                hit  = cke[1];
                rank = 2'h3;
            end
            default: begin
                hit  = 1'b0;
                rank = 2'h0;
            end
        endcase
    end
endmodule // ddr3cd_rank_decode

// ===== hdl/ddr3cd_decoder.v
// DDR3 command bus decoder: samples the control group and classifies each bus cycle
`include "ddr3cd_defs.vh"

module ddr3cd_decoder (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       bus_clk,
    input  wire [1:0] slot_a_clock_enable,
    input  wire [1:0] second_slot_clock_enable,
    input  wire [1:0] third_slot_clock_enable,
    input  wire [3:0] slot_a_rank_select_n,
    input  wire [1:0] second_slot_rank_select_n,
    input  wire [1:0] third_slot_rank_select_n,
    input  wire [2:0] bank_addr,
    input  wire [2:0] addr_high,
    input  wire       addr_burst_chop_n,
    input  wire       addr_auto_precharge,
    input  wire       row_strobe_n,
    input  wire       column_strobe_n,
    input  wire       write_enable_n,
    input  wire       three_slot_mode,
    input  wire [1:0] burst_mode,
    input  wire [3:0] cas_latency,
    input  wire [1:0] additive_latency,
    input  wire [3:0] write_latency,
    input  wire       registered_modules,
    output reg        cycle_strobe,
    output reg  [3:0] cmd_code,
    output reg        deselect_cycle,
    output reg  [1:0] cmd_slot,
    output reg  [1:0] cmd_rank,
    output reg  [2:0] cmd_bank,
    output reg  [1:0] cmd_mode_register,
    output reg  [2:0] cmd_addr_high,
    output reg        cmd_burst8,
    output reg        read_data_valid,
    output reg        write_data_valid
);

    // Synchronised copy of the bus clock and control group
    wire [`DDR3CD_GRP_W-1:0] raw_group;
    wire [`DDR3CD_GRP_W-1:0] grp;

    // Rank decode results per slot
    wire       hit_a;
    wire       hit_b;
    wire       hit_c;
    wire [1:0] rank_a;
    wire [1:0] rank_b;
    wire [1:0] rank_c;

    // Bus clock edge detection
    reg        bus_clk_prev;
    wire       bus_edge;

    // Pending data cycles, bit i is the bus cycle i+1 ahead of the current one
    reg [`DDR3CD_SCHED_W-1:0] read_sched;
    reg [`DDR3CD_SCHED_W-1:0] write_sched;

    // Combinational classification of the sampled cycle
    reg [3:0] next_cmd;
    reg [1:0] next_slot;
    reg [1:0] next_rank;
    reg [2:0] next_bank;
    reg [1:0] next_mode_reg;
    reg       next_burst8;
    reg       rank_hit;
    reg [`DDR3CD_SCHED_W-1:0] next_read_sched;
    reg [`DDR3CD_SCHED_W-1:0] next_write_sched;

    // Effective latencies in bus cycles
    wire [3:0] cl_eff;
    wire [3:0] cwl_eff;
    reg  [4:0] al_eff;
    wire [4:0] read_lat;
    wire [4:0] write_lat;

    // Clamp a configured latency into its legal range
    function [3:0] clamp_lat;
        input [3:0] val;
        input [3:0] lo;
        input [3:0] hi;
        begin
            if (val < lo) begin
                clamp_lat = lo;
            end else if (val > hi) begin
                clamp_lat = hi;
            end else begin
                clamp_lat = val;
            end
        end
    endfunction

    // Mark the bus cycles of one burst, starting lat cycles after the command
    function [`DDR3CD_SCHED_W-1:0] burst_mask;
        input [4:0] lat;
        input       burst8;
        reg   [`DDR3CD_SCHED_W-1:0] span;
        begin
            span = burst8 ? `DDR3CD_BURST8_CLK : `DDR3CD_BURST4_CLK;
            burst_mask = span << (lat - 5'h01);
        end
    endfunction

    // Pin group order follows the three slot control group, top bit is the bus clock
    assign raw_group = {bus_clk,
                        third_slot_clock_enable,
                        second_slot_clock_enable,
                        slot_a_clock_enable,
                        third_slot_rank_select_n,
                        second_slot_rank_select_n,
                        slot_a_rank_select_n,
                        bank_addr,
                        addr_high,
                        addr_burst_chop_n,
                        addr_auto_precharge,
                        row_strobe_n,
                        column_strobe_n,
                        write_enable_n};

    // Clock and control pass the same chain so their alignment is kept
    ddr3cd_sync #(
        .W(`DDR3CD_GRP_W)
    ) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (raw_group),
        .q     (grp)
    );

    // Slot A uses four selects; slots B and C use two, upper pair held high
    ddr3cd_rank_decode u_rank_a (
        .sel_n (grp[`DDR3CD_CS_A_HI:`DDR3CD_CS_A_LO]),
        .cke   (grp[`DDR3CD_CKE_A_HI:`DDR3CD_CKE_A_LO]),
        .hit   (hit_a),
        .rank  (rank_a)
    );

    ddr3cd_rank_decode u_rank_b (
        .sel_n ({2'h3, grp[`DDR3CD_CS_B_HI:`DDR3CD_CS_B_LO]}),
        .cke   (grp[`DDR3CD_CKE_B_HI:`DDR3CD_CKE_B_LO]),
        .hit   (hit_b),
        .rank  (rank_b)
    );

    ddr3cd_rank_decode u_rank_c (
        .sel_n ({2'h3, grp[`DDR3CD_CS_C_HI:`DDR3CD_CS_C_LO]}),
        .cke   (grp[`DDR3CD_CKE_C_HI:`DDR3CD_CKE_C_LO]),
        .hit   (hit_c),
        .rank  (rank_c)
    );

    // One classification per rising bus clock edge
    assign bus_edge = grp[`DDR3CD_BUS_CLK] & ~bus_clk_prev;

    // Latency arithmetic; out of range CL and CWL are clamped rather than rejected, an undefined AL code counts as zero
    assign cl_eff  = clamp_lat(cas_latency, `DDR3CD_CL_MIN, `DDR3CD_CL_MAX);
    assign cwl_eff = clamp_lat(write_latency, `DDR3CD_CWL_MIN, `DDR3CD_CWL_MAX);

    always @* begin
        case (additive_latency)
            `DDR3CD_AL_CL_M1: al_eff = {1'b0, cl_eff} - 5'h01;
            `DDR3CD_AL_CL_M2: al_eff = {1'b0, cl_eff} - 5'h02;
            default:          al_eff = 5'h00;
        endcase
    end

    assign read_lat  = {1'b0, cl_eff} + al_eff + {4'h0, registered_modules};
    assign write_lat = {1'b0, cwl_eff} + {4'h0, registered_modules};

    // Slot select; A wins over B over C when several slots select together
    always @* begin
        rank_hit  = 1'b0;
        next_slot = `DDR3CD_SLOT_A;
        next_rank = 2'h0;
        if (hit_a) begin
            rank_hit  = 1'b1;
            next_rank = rank_a;
        end else if (three_slot_mode && hit_b) begin
            rank_hit  = 1'b1;
            next_slot = `DDR3CD_SLOT_B;
            next_rank = rank_b;
        end else if (three_slot_mode && hit_c) begin
            rank_hit  = 1'b1;
            next_slot = `DDR3CD_SLOT_C;
            next_rank = rank_c;
        end
    end

    // Strobe decode, same encoding for every slot
    always @* begin
        next_cmd      = `DDR3CD_CMD_DESEL;
        next_bank     = 3'h0;
        next_mode_reg = 2'h0;
        if (rank_hit) begin
            case ({grp[`DDR3CD_RAS_N], grp[`DDR3CD_CAS_N], grp[`DDR3CD_WE_N]})
                3'h0: begin
                    next_cmd      = `DDR3CD_CMD_MRS;
                    next_mode_reg = grp[`DDR3CD_BA_LO+1:`DDR3CD_BA_LO];
                end
                3'h1: next_cmd = `DDR3CD_CMD_REF;
                3'h2: begin
                    if (grp[`DDR3CD_AP]) begin
                        next_cmd = `DDR3CD_CMD_PREA;
                    end else begin
                        next_cmd  = `DDR3CD_CMD_PRE;
                        next_bank = grp[`DDR3CD_BA_HI:`DDR3CD_BA_LO];
                    end
                end
                3'h3: begin
                    next_cmd  = `DDR3CD_CMD_ACT;
                    next_bank = grp[`DDR3CD_BA_HI:`DDR3CD_BA_LO];
                end
                3'h4: begin
                    next_cmd  = grp[`DDR3CD_AP] ? `DDR3CD_CMD_WRA : `DDR3CD_CMD_WR;
                    next_bank = grp[`DDR3CD_BA_HI:`DDR3CD_BA_LO];
                end
                3'h5: begin
                    next_cmd  = grp[`DDR3CD_AP] ? `DDR3CD_CMD_RDA : `DDR3CD_CMD_RD;
                    next_bank = grp[`DDR3CD_BA_HI:`DDR3CD_BA_LO];
                end
                3'h6: next_cmd = grp[`DDR3CD_AP] ? `DDR3CD_CMD_ZQCL : `DDR3CD_CMD_ZQCS;
                3'h7: next_cmd = `DDR3CD_CMD_NOP;
                default: next_cmd = `DDR3CD_CMD_DESEL;
            endcase
        end else begin
            next_cmd = `DDR3CD_CMD_DESEL;
        end
    end

    // Burst length per command
    always @* begin
        case (burst_mode)
            `DDR3CD_BL8:    next_burst8 = 1'b1;
            `DDR3CD_BL_OTF: next_burst8 = grp[`DDR3CD_BC_N];
            default:        next_burst8 = 1'b0;
        endcase
    end

    // Advance the data schedules and add the burst of a new read or write
    always @* begin
        next_read_sched  = read_sched >> 1;
        next_write_sched = write_sched >> 1;
        if (next_cmd == `DDR3CD_CMD_RD || next_cmd == `DDR3CD_CMD_RDA) begin
            next_read_sched = next_read_sched | burst_mask(read_lat, next_burst8);
        end
        if (next_cmd == `DDR3CD_CMD_WR || next_cmd == `DDR3CD_CMD_WRA) begin
            next_write_sched = next_write_sched | burst_mask(write_lat, next_burst8);
        end
    end

    // Edge history of the synchronised bus clock
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_clk_prev <= 1'b0;
        end else begin
            bus_clk_prev <= grp[`DDR3CD_BUS_CLK];
        end
    end

    // Results hold for a whole bus cycle so a slow reader sees them between edges
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_strobe      <= 1'b0;
            cmd_code          <= `DDR3CD_CMD_DESEL;
            deselect_cycle    <= 1'b1;
            cmd_slot          <= `DDR3CD_SLOT_A;
            cmd_rank          <= 2'h0;
            cmd_bank          <= 3'h0;
            cmd_mode_register <= 2'h0;
            cmd_addr_high     <= 3'h0;
            cmd_burst8        <= 1'b0;
            read_data_valid   <= 1'b0;
            write_data_valid  <= 1'b0;
            read_sched        <= {`DDR3CD_SCHED_W{1'b0}};
            write_sched       <= {`DDR3CD_SCHED_W{1'b0}};
        end else begin
            cycle_strobe <= bus_edge;
            if (bus_edge) begin
                cmd_code          <= next_cmd;
                deselect_cycle    <= (next_cmd == `DDR3CD_CMD_DESEL);
                cmd_slot          <= next_slot;
                cmd_rank          <= next_rank;
                cmd_bank          <= next_bank;
                cmd_mode_register <= next_mode_reg;
                cmd_addr_high     <= grp[`DDR3CD_AHI_HI:`DDR3CD_AHI_LO];
                cmd_burst8        <= next_burst8;
                read_data_valid   <= read_sched[0];
                write_data_valid  <= write_sched[0];
                read_sched        <= next_read_sched;
                write_sched       <= next_write_sched;
            end
        end
    end

endmodule // ddr3cd_decoder

// ===== bench/ddr3cd_decoder_sva.sv
// Concurrent checks on the command decoder's ports
`include "ddr3cd_defs.vh"

module ddr3cd_decoder_sva (
    input wire       mclk,
    input wire       rst_n,
    input wire       bus_clk,
    input wire       three_slot_mode,
    input wire [1:0] burst_mode,
    input wire       cycle_strobe,
    input wire [3:0] cmd_code,
    input wire       deselect_cycle,
    input wire [1:0] cmd_slot,
    input wire [1:0] cmd_rank,
    input wire [2:0] cmd_bank,
    input wire [1:0] cmd_mode_register,
    input wire [2:0] cmd_addr_high,
    input wire       cmd_burst8,
    input wire       read_data_valid,
    input wire       write_data_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // A rise of the raw bus clock pin as seen by two mclk samples
    sequence s_bus_rise;
        !bus_clk ##1 bus_clk;
    endsequence

    // One classification burst of work after each rise
    sequence s_classified;
        ##[2:7] cycle_strobe;
    endsequence

    // Synchroniser delay is bounded, so a missing strobe shows within seven cycles
    a_strobe_follows: assert property (s_bus_rise |-> s_classified)
        else $error("no classification after bus clock rise");
    a_strobe_single: assert property (cycle_strobe |=> !cycle_strobe [*5])
        else $error("classification strobe repeated too soon");
    a_outputs_hold: assert property (!cycle_strobe |-> $stable({cmd_code, deselect_cycle, cmd_slot,
        cmd_rank, cmd_bank, cmd_mode_register, cmd_addr_high, cmd_burst8, read_data_valid, write_data_valid}))
        else $error("outputs changed between classifications");
    a_desel_code: assert property (cycle_strobe |-> deselect_cycle == (cmd_code == `DDR3CD_CMD_DESEL))
        else $error("deselect flag disagrees with command code");
    a_desel_fields: assert property (cycle_strobe && deselect_cycle |-> {cmd_slot, cmd_rank, cmd_bank} == 7'h00)
        else $error("deselect cycle reports a target");
    a_bank_scope: assert property (cycle_strobe && !(cmd_code inside {`DDR3CD_CMD_PRE, `DDR3CD_CMD_ACT,
        `DDR3CD_CMD_WR, `DDR3CD_CMD_WRA, `DDR3CD_CMD_RD, `DDR3CD_CMD_RDA}) |-> cmd_bank == 3'h0)
        else $error("bank reported for a command without one");
    a_mr_scope: assert property (cycle_strobe && cmd_code != `DDR3CD_CMD_MRS |-> cmd_mode_register == 2'h0)
        else $error("mode register reported outside mode register set");
    a_slot_single: assert property (cycle_strobe && !three_slot_mode |-> cmd_slot == `DDR3CD_SLOT_A)
        else $error("slot B or C reported in single slot mode");
    a_slot_rank: assert property (cycle_strobe && cmd_slot != `DDR3CD_SLOT_A |-> cmd_slot != 2'h3 && !cmd_rank[1])
        else $error("bad slot or rank for slot B or C");
    a_burst_fixed: assert property (cycle_strobe && cmd_code inside {[`DDR3CD_CMD_WR:`DDR3CD_CMD_RDA]}
        && burst_mode != `DDR3CD_BL_OTF |-> cmd_burst8 == (burst_mode == `DDR3CD_BL8))
        else $error("burst length differs from fixed burst mode");
endmodule // ddr3cd_decoder_sva

bind ddr3cd_decoder ddr3cd_decoder_sva u_sva (
    .mclk(mclk), .rst_n(rst_n), .bus_clk(bus_clk), .three_slot_mode(three_slot_mode), .burst_mode(burst_mode),
    .cycle_strobe(cycle_strobe), .cmd_code(cmd_code), .deselect_cycle(deselect_cycle), .cmd_slot(cmd_slot),
    .cmd_rank(cmd_rank), .cmd_bank(cmd_bank), .cmd_mode_register(cmd_mode_register),
    .cmd_addr_high(cmd_addr_high), .cmd_burst8(cmd_burst8), .read_data_valid(read_data_valid),
    .write_data_valid(write_data_valid)
);

// ===== bench/ddr3cd_ctl_model.sv
// Memory controller stand-in: free running bus clock and command pins
module ddr3cd_ctl_model (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [24:0] next_vec,
    output reg         taken,
    output reg         bus_clk,
    output reg  [24:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;

    reg [2:0] phase;

    // Eight mclk per bus clock; pins change at the fall, four mclk clear of each rise
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 3'h3;
            bus_clk <= 1'b0;
            taken <= 1'b0;
            pins <= {6'h00, 8'hff, 8'h00, 3'h7};
        end else begin
            phase <= phase + 3'h1;
            bus_clk <= (phase + 3'h1) < 3'h4;
            taken <= (phase == 3'h3);
            if (phase == 3'h3) begin
                pins <= next_vec;
            end
        end
    end
endmodule // ddr3cd_ctl_model

// ===== bench/tb.sv
// Random and corner command streams checked against a decode model
`include "ddr3cd_defs.vh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    reg          mclk = 1'b0;
    reg          rst_n;
    reg          three_slot_mode;
    reg          registered_modules;
    reg  [1:0]   burst_mode;
    reg  [1:0]   additive_latency;
    reg  [3:0]   cas_latency;
    reg  [3:0]   write_latency;
    reg  [24:0]  next_vec;
    reg  [31:0]  lfsr;
    reg  [24:0]  vq[$];
    reg  [24:0]  sv;
    reg  [12:0]  e;
    reg  [2047:0] rd_exp;
    reg  [2047:0] wr_exp;
    reg          quiet;
    reg          b8;
    integer      err_count, n_compared, ncmd, nstb, timer, k, j, tgt, rl, wl;
    wire         taken, bus_clk, cycle_strobe, deselect_cycle, cmd_burst8, read_data_valid, write_data_valid;
    wire [24:0]  pins;
    wire [3:0]   cmd_code;
    wire [1:0]   cmd_slot, cmd_rank, cmd_mode_register;
    wire [2:0]   cmd_bank, cmd_addr_high;

    ddr3cd_ctl_model u_ctl (.mclk(mclk), .rst_n(rst_n), .next_vec(next_vec), .taken(taken), .bus_clk(bus_clk),
        .pins(pins));

    ddr3cd_decoder u_dut (
        .mclk(mclk), .rst_n(rst_n), .bus_clk(bus_clk), .slot_a_clock_enable(pins[20:19]),
        .second_slot_clock_enable(pins[22:21]), .third_slot_clock_enable(pins[24:23]),
        .slot_a_rank_select_n(pins[14:11]), .second_slot_rank_select_n(pins[16:15]),
        .third_slot_rank_select_n(pins[18:17]), .bank_addr(pins[10:8]), .addr_high(pins[7:5]),
        .addr_burst_chop_n(pins[4]), .addr_auto_precharge(pins[3]), .row_strobe_n(pins[2]),
        .column_strobe_n(pins[1]), .write_enable_n(pins[0]), .three_slot_mode(three_slot_mode),
        .burst_mode(burst_mode), .cas_latency(cas_latency), .additive_latency(additive_latency),
        .write_latency(write_latency), .registered_modules(registered_modules), .cycle_strobe(cycle_strobe),
        .cmd_code(cmd_code), .deselect_cycle(deselect_cycle), .cmd_slot(cmd_slot), .cmd_rank(cmd_rank),
        .cmd_bank(cmd_bank), .cmd_mode_register(cmd_mode_register), .cmd_addr_high(cmd_addr_high),
        .cmd_burst8(cmd_burst8), .read_data_valid(read_data_valid), .write_data_valid(write_data_valid)
    );

    function [31:0] lfsr_next(input [31:0] x);
        lfsr_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h0020_0007 : 32'h0000_0000);
    endfunction

    // Latency settings outside the legal range count as the nearest limit
    function integer lat_lim(input [3:0] v, input [3:0] lo, input [3:0] hi);
        lat_lim = (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    // Expected {code, slot, rank, bank, mode register}; slot A wins over B, B over C
    function automatic [12:0] exp_cls(input [24:0] v, input ts);
        reg [3:0] c;
        reg [1:0] s;
        reg [1:0] r;
        reg       hit;
        integer   i;
        hit = 1'b0;
        s = `DDR3CD_SLOT_A;
        r = 2'h0;
        for (i = 0; i < 4; i = i + 1) begin
            if (v[14:11] == ~(4'h1 << i) && v[19 + i % 2]) begin
                hit = 1'b1;
                r = i[1:0];
            end
        end
        for (i = 0; i < 4; i = i + 1) begin
            if (!hit && ts && v[15 + 2 * (i / 2) +: 2] == ~(2'h1 << i % 2) && v[21 + i]) begin
                hit = 1'b1;
                r = {1'b0, i[0]};
                s = (i < 2) ? `DDR3CD_SLOT_B : `DDR3CD_SLOT_C;
            end
        end
        case (v[2:0])
            3'h0: c = `DDR3CD_CMD_MRS;
            3'h1: c = `DDR3CD_CMD_REF;
            3'h2: c = v[3] ? `DDR3CD_CMD_PREA : `DDR3CD_CMD_PRE;
            3'h3: c = `DDR3CD_CMD_ACT;
            3'h4: c = v[3] ? `DDR3CD_CMD_WRA : `DDR3CD_CMD_WR;
            3'h5: c = v[3] ? `DDR3CD_CMD_RDA : `DDR3CD_CMD_RD;
            3'h6: c = v[3] ? `DDR3CD_CMD_ZQCL : `DDR3CD_CMD_ZQCS;
            default: c = `DDR3CD_CMD_NOP;
        endcase
        if (!hit) c = `DDR3CD_CMD_DESEL;
        exp_cls = {c, hit ? s : 2'h0, r, (c == 4'h3 || c inside {[4'h5:4'h9]}) ? v[10:8] : 3'h0,
            (c == `DDR3CD_CMD_MRS) ? v[9:8] : 2'h0};
    endfunction

    // Corner vectors: every strobe and auto precharge pairing except mode register set with auto precharge low, then awkward selects
    function [24:0] corner(input [4:0] i, input [31:0] r);
        case (i)
            5'd16: corner = {6'h3f, 4'hf, 4'hc, r[7:0], 3'h3};
            5'd17: corner = {6'h3d, 4'hf, 4'hd, r[7:0], 3'h5};
            5'd18: corner = {6'h3f, 4'he, 4'hb, r[7:0], 3'h0};
            5'd19: corner = {6'h3f, 4'hb, 4'hf, r[7:0], 3'h4};
            default: corner = {6'h3f, 4'hf, ~(4'h1 << i[1:0]), r[7:1], i[3], i[2:0]};
        endcase
    endfunction

    task check(input string what, input [15:0] expv, input [15:0] got);
        n_compared = n_compared + 1;
        if (got !== expv) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
        end
    endtask

    task print_verdict;
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always #12.5 mclk = ~mclk;

    // Timeout guard in case the controller model stops taking commands
    always @(posedge mclk) begin
        timer = timer + 1;
        if (timer == 20000) begin
            err_count = err_count + 1;
            print_verdict;
        end
    end

    // Queue each driven vector with its data schedule, then score each classification
    always @(posedge mclk) begin
        if (taken) begin
            vq.push_back(pins);
            e = exp_cls(pins, three_slot_mode);
            b8 = burst_mode == `DDR3CD_BL8 || (burst_mode == `DDR3CD_BL_OTF && pins[4]);
            rl = lat_lim(cas_latency, `DDR3CD_CL_MIN, `DDR3CD_CL_MAX);
            rl = rl + registered_modules + (additive_latency == 2'h1 ? rl - 1 : additive_latency == 2'h2 ? rl - 2 : 0);
            wl = lat_lim(write_latency, `DDR3CD_CWL_MIN, `DDR3CD_CWL_MAX) + registered_modules;
            for (j = 0; j < (b8 ? 4 : 2); j = j + 1) begin
                if (e[12:9] == `DDR3CD_CMD_RD || e[12:9] == `DDR3CD_CMD_RDA) rd_exp[ncmd + rl + j] = 1'b1;
                if (e[12:9] == `DDR3CD_CMD_WR || e[12:9] == `DDR3CD_CMD_WRA) wr_exp[ncmd + wl + j] = 1'b1;
            end
            ncmd = ncmd + 1;
            lfsr = lfsr_next(lfsr);
            if (quiet) next_vec <= {6'h3f, 8'hff, lfsr[10:0]};
            else if (ncmd < 20) next_vec <= corner(ncmd[4:0], lfsr);
            else next_vec <= {lfsr[20:15] | {6{lfsr[7]}}, lfsr[11] ? ~(2'h1 << lfsr[12]) : lfsr[14:13],
                lfsr[7] ? ~(2'h1 << lfsr[8]) : lfsr[10:9], lfsr[0] ? ~(4'h1 << lfsr[2:1]) : lfsr[6:3], lfsr[31:21]};
        end
        if (rst_n && cycle_strobe) begin
            check("queue", 16'h1, {15'h0, vq.size() != 0});
            if (vq.size() != 0) begin
                sv = vq.pop_front();
                e = exp_cls(sv, three_slot_mode);
                b8 = burst_mode == `DDR3CD_BL8 || (burst_mode == `DDR3CD_BL_OTF && sv[4]);
                check("class", {3'h0, e}, {3'h0, cmd_code, cmd_slot, cmd_rank, cmd_bank, cmd_mode_register});
                check("deselect", {15'h0, e[12:9] == 4'h0}, {15'h0, deselect_cycle});
                check("addr high", {13'h0, sv[7:5]}, {13'h0, cmd_addr_high});
                if (e[12:9] inside {[4'h6:4'h9]}) check("burst8", {15'h0, b8}, {15'h0, cmd_burst8});
            end
            check("read data", {15'h0, rd_exp[nstb]}, {15'h0, read_data_valid});
            check("write data", {15'h0, wr_exp[nstb]}, {15'h0, write_data_valid});
            nstb = nstb + 1;
        end
    end

    // Batches of traffic; settings change only after a drain of deselect cycles
    initial begin
        rst_n = 1'b0;
        three_slot_mode = 1'b1;
        registered_modules = 1'b0;
        burst_mode = `DDR3CD_BL4;
        additive_latency = `DDR3CD_AL_ZERO;
        cas_latency = `DDR3CD_CL_MIN;
        write_latency = `DDR3CD_CWL_MIN;
        next_vec = {6'h3f, 8'hff, 11'h7ff};
        lfsr = 32'h80f5_930c;
        {err_count, n_compared, ncmd, nstb, timer} = 0;
        {rd_exp, wr_exp} = 0;
        quiet = 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        for (k = 0; k < 12; k = k + 1) begin
            if (k > 0) begin
                @(posedge mclk);
                burst_mode <= k[1:0];
                additive_latency <= lfsr[1:0];
                cas_latency <= 4'h4 + {1'b0, lfsr[4:2]};              // Reaches 4 and 11 to hit the clamp
                write_latency <= 4'h4 + {1'b0, lfsr[6:5], lfsr[9]};
                registered_modules <= lfsr[7];
                three_slot_mode <= lfsr[8];
            end
            quiet = 1'b0;
            tgt = ncmd + 50;
            wait (ncmd >= tgt);
            quiet = 1'b1;
            wait (ncmd >= tgt + 30);
        end
        check("strobe count", 16'h1, {15'h0, ncmd - nstb <= 2});
        print_verdict;
    end
endmodule // tb
